/* rtl/vps_regs.svh */
// Purpose: Register map, field positions, reset values and sizes
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes:   Definitions only
`ifndef VPS_REGS_SVH
`define VPS_REGS_SVH

// Register byte offsets (address bits [3:0])
`define VPS_OFF_CTRL    4'h0
`define VPS_OFF_STATUS  4'h4
`define VPS_OFF_SHIFT   4'h8

// Control register fields
`define VPS_CTRL_RUN    0
`define VPS_CTRL_PRST   1
`define VPS_CTRL_RUN_RST 1'b1

// Status register fields
`define VPS_ST_CNT_LSB  0
`define VPS_ST_OVR      3
`define VPS_ST_MODE_LSB 4
`define VPS_ST_LVL_LSB  8
`define VPS_ST_PEND     16

// Sizes
`define VPS_WORD_W      16
`define VPS_MID_BIT     8
`define VPS_STAGE_DEPTH 3'd4
`define VPS_BUF_DEPTH   32
`define VPS_BUF_LVL_W   6
`define VPS_BUS_ZERO    32'h0000_0000

`endif

/* rtl/vps_pkg.sv */
// Purpose: Types shared by the video shifter and its testbench
// Assumes: vps_regs.svh supplies the sizes
// Notes:   Mode decode is shared, so it lives here as a function
`include "vps_regs.svh"
package vps_pkg;

  typedef enum logic [1:0] {
    VPS_MODE_LATCH,
    VPS_MODE_FLOP,
    VPS_MODE_FIFO
  } vps_mode_t;

  // Control pins as one bundle
  typedef struct packed {
    logic mode_sel_bit1;
    logic mode_sel_bit0;
    logic freeze;
    logic force_out;
    logic force_level;
    logic load_en;
  } vps_ctl_t;

  // Every asynchronous pin, synchronised together
  typedef struct packed {
    logic                   wr_strobe;
    logic [`VPS_WORD_W-1:0] wr_data;
    vps_ctl_t               ctl;
    logic                   load;
    logic                   pix;
    logic                   ser_in;
  } vps_pins_t;

  function automatic vps_mode_t vps_decode_mode(input logic m1,
                                                input logic m0);
    if (m0)
      return VPS_MODE_LATCH;
    else if (m1)
      return VPS_MODE_FIFO;
    else
      return VPS_MODE_FLOP;
  endfunction

endpackage

/* rtl/vps_fifo.sv */
// Purpose: Word buffer with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   DEPTH must be a power of two
`timescale 1ns/1ns
module vps_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  // Fill side
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [WIDTH-1:0]         in_data_i,
  // Drain side
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [WIDTH-1:0]              out_data_o,
  // Fill level
  output logic [$clog2(DEPTH):0]        level_o
);
  localparam int AW = $clog2(DEPTH);

  logic [AW:0]      wp;
  logic [AW:0]      rp;
  logic [AW:0]      next_wp;
  logic [AW:0]      next_rp;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign level_o     = wp - rp;
  assign in_ready_o  = level_o != (AW + 1)'(DEPTH);
  assign out_valid_o = level_o != '0;
  assign out_data_o  = mem[rp[AW-1:0]];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end

  // Storage needs no reset; only pointers gate what is visible
  always_ff @(posedge clk_i) begin
    if (push)
      mem[wp[AW-1:0]] <= in_data_i;
  end

endmodule // vps_fifo

/* rtl/vps_video_shifter.sv */
// Purpose: Sixteen-bit video shifter with latch/flop/FIFO input stage
// Assumes: 25 MHz clk_i; all pins but the Avalon slave asynchronous, synchronised twice
// Notes:   Pixel clock is sampled, so it must run well below clk_i/2
// What this block does
// - Sixteen-bit shifter fed by a configurable stage
// - Three stage modes chosen by two pins
// - Words enter through the write strobe, or in latch mode while it is low
// - Load strobe moves held word into shifter
// - Pixel clock rising edges shift one bit
// - Freeze stops shifting and holds the output
// - Force holds output bit at given level
// - Disabled load-enable ignores load strobes
// - Second serial output taps bit eight
// - Bit0 high latch; both low flop; else FIFO
// - First pixel edge after load strobe loads
// - Bit zero leaves first, bit fifteen last
// - Pointers clear at reset, mode bit 1 fall while load is high, or control PRST write
`timescale 1ns/1ns
`include "vps_regs.svh"
module vps_video_shifter
  import vps_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  // Avalon-MM slave
  input  wire logic [3:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic [31:0]                 avs_readdata_o,
  output logic                        avs_waitrequest_o,
  // Word writer pins
  input  wire logic                   wr_strobe_i,
  input  wire logic [`VPS_WORD_W-1:0] wr_data_i,
  output logic                        wr_ready_o,
  // Control pins and strobes
  input  wire vps_pkg::vps_ctl_t      ctl_i,
  input  wire logic                   load_strobe_i,
  input  wire logic                   pix_clk_i,
  input  wire logic                   ser_in_i,
  // Serial outputs
  output logic                        ser_out_o,
  output logic                        mid_tap_output_o
);
  import vps_pkg::*;

  localparam int W = `VPS_WORD_W;

  vps_pins_t              pins;
  vps_pins_t              s1;
  vps_pins_t              s2;
  vps_pins_t              sp;
  vps_mode_t              mode;
  logic                   pix_rise;
  logic                   load_rise;
  logic                   wr_rise;
  logic                   m1_fall;
  logic                   shift_ev;
  logic                   ld;
  logic                   pend;
  logic                   next_pend;
  logic [W-1:0]           shreg;
  logic [W-1:0]           next_shreg;
  logic                   next_out;
  logic                   next_mid;
  logic [W-1:0]           held;
  logic [W-1:0]           latch_q;
  logic [W-1:0]           next_latch;
  logic [W-1:0]           flop_q;
  logic [W-1:0]           next_flop;
  logic [W-1:0]           stage [4];
  logic [1:0]             wptr;
  logic [1:0]             rptr;
  logic [2:0]             cnt;
  logic [1:0]             next_wptr;
  logic [1:0]             next_rptr;
  logic [2:0]             next_cnt;
  logic                   stg_ready;
  logic                   stg_wr;
  logic                   fifo_wr;
  logic                   fifo_ld;
  logic                   prst;
  logic                   buf_valid;
  logic [W-1:0]           buf_data;
  logic [`VPS_BUF_LVL_W-1:0] buf_lvl;
  logic                   run;
  logic                   next_run;
  logic                   prst_req;
  logic                   next_prst_req;
  logic                   ovr;
  logic                   next_ovr;
  logic                   ack;
  logic                   next_ack;
  logic [31:0]            rdata;
  logic [31:0]            next_rdata;
  logic                   do_wr;

  // Pin synchroniser; only s2 and later are read by logic
  assign pins = '{wr_strobe: wr_strobe_i, wr_data: wr_data_i, ctl: ctl_i,
                  load: load_strobe_i, pix: pix_clk_i, ser_in: ser_in_i};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1 <= '0;
      s2 <= '0;
      sp <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      sp <= s2;
    end
  end

  assign pix_rise  = s2.pix & ~sp.pix;
  assign load_rise = s2.load & ~sp.load;
  assign wr_rise   = s2.wr_strobe & ~sp.wr_strobe;
  assign m1_fall   = ~s2.ctl.mode_sel_bit1 & sp.ctl.mode_sel_bit1;
  assign mode      = vps_decode_mode(s2.ctl.mode_sel_bit1,
                                     s2.ctl.mode_sel_bit0);

  // Buffer between the writer pins and the input stage
  vps_fifo #(
    .WIDTH (W),
    .DEPTH (`VPS_BUF_DEPTH)
  ) u_buf (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (wr_rise),
    .in_ready_o  (wr_ready_o),
    .in_data_i   (s2.wr_data),
    .out_valid_o (buf_valid),
    .out_ready_i (stg_ready),
    .out_data_o  (buf_data),
    .level_o     (buf_lvl)
  );

  // Input stage; a full four-word stage stalls the buffer, not the writer
  assign stg_ready = (mode != VPS_MODE_FIFO) ||
                     (cnt < `VPS_STAGE_DEPTH);
  assign stg_wr    = buf_valid & stg_ready;
  assign fifo_wr   = stg_wr & (mode == VPS_MODE_FIFO);
  assign fifo_ld   = ld & (mode == VPS_MODE_FIFO) & (cnt != 3'd0);
  assign prst      = (m1_fall & s2.load) | prst_req;

  always_comb begin
    next_latch = latch_q;
    if (mode == VPS_MODE_LATCH && !s2.wr_strobe)
      next_latch = s2.wr_data;
    next_flop = stg_wr ? buf_data : flop_q;
    next_wptr = wptr;
    next_rptr = rptr;
    next_cnt  = cnt;
    if (prst) begin
      next_wptr = 2'd0;
      next_rptr = 2'd0;
      next_cnt  = 3'd0;
    end else begin
      if (fifo_wr)
        next_wptr = wptr + 2'd1;
      if (fifo_ld)
        next_rptr = rptr + 2'd1;
      next_cnt = cnt + {2'd0, fifo_wr} - {2'd0, fifo_ld};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      latch_q <= '0;
      flop_q  <= '0;
      wptr    <= 2'd0;
      rptr    <= 2'd0;
      cnt     <= 3'd0;
    end else begin
      latch_q <= next_latch;
      flop_q  <= next_flop;
      wptr    <= next_wptr;
      rptr    <= next_rptr;
      cnt     <= next_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (fifo_wr && !prst)
      stage[wptr] <= buf_data;
  end

  always_comb begin
    unique case (mode)
      VPS_MODE_LATCH: held = latch_q;
      VPS_MODE_FLOP:  held = flop_q;
      VPS_MODE_FIFO:  held = stage[rptr];
      default:        held = flop_q;
    endcase
  end

  // Load request waits for the next pixel edge; freeze defers it
  assign shift_ev = pix_rise & run & ~s2.ctl.freeze;
  assign ld       = shift_ev & pend;

  always_comb begin
    next_pend = pend;
    if (ld)
      next_pend = 1'b0;
    if (load_rise)
      next_pend = 1'b1;
    if (!s2.ctl.load_en)
      next_pend = 1'b0;
  end

  // Shifter: bit 0 is the output end, serial input enters at the top
  always_comb begin
    next_shreg = shreg;
    next_out   = ser_out_o;
    next_mid   = mid_tap_output_o;
    if (shift_ev) begin
      if (ld)
        next_shreg = held;
      else
        next_shreg = {s2.ser_in, shreg[W-1:1]};
      next_out = s2.ctl.force_out ? s2.ctl.force_level
                                  : next_shreg[0];
      next_mid = s2.ctl.force_out ? s2.ctl.force_level
                                  : next_shreg[`VPS_MID_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pend             <= 1'b0;
      shreg            <= '0;
      ser_out_o        <= 1'b0;
      mid_tap_output_o <= 1'b0;
    end else begin
      pend             <= next_pend;
      shreg            <= next_shreg;
      ser_out_o        <= next_out;
      mid_tap_output_o <= next_mid;
    end
  end

  // Avalon slave: every access answers one cycle after it appears
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign avs_readdata_o    = rdata;
  assign do_wr             = avs_write_i & ack;

  always_comb begin
    next_ack      = (avs_read_i | avs_write_i) & ~ack;
    next_rdata    = rdata;
    next_run      = run;
    next_prst_req = 1'b0;
    next_ovr      = ovr;
    if (avs_read_i && !ack) begin
      next_rdata = `VPS_BUS_ZERO;
      unique case (avs_address_i)
        `VPS_OFF_CTRL:
          next_rdata[`VPS_CTRL_RUN] = run;
        `VPS_OFF_STATUS: begin
          next_rdata[`VPS_ST_CNT_LSB +: 3] = cnt;
          next_rdata[`VPS_ST_OVR] = ovr;
          next_rdata[`VPS_ST_MODE_LSB +: 2] = mode;
          next_rdata[`VPS_ST_LVL_LSB +: `VPS_BUF_LVL_W] = buf_lvl;
          next_rdata[`VPS_ST_PEND] = pend;
        end
        `VPS_OFF_SHIFT:
          next_rdata[W-1:0] = shreg;
        default:
          next_rdata = `VPS_BUS_ZERO;
      endcase
    end
    if (do_wr && avs_byteenable_i[0]) begin
      if (avs_address_i == `VPS_OFF_CTRL) begin
        next_run      = avs_writedata_i[`VPS_CTRL_RUN];
        next_prst_req = avs_writedata_i[`VPS_CTRL_PRST];
      end
      if (avs_address_i == `VPS_OFF_STATUS &&
          avs_writedata_i[`VPS_ST_OVR])
        next_ovr = 1'b0;
    end
    // A dropped word in the same cycle as the clear still counts
    if (wr_rise && !wr_ready_o)
      next_ovr = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack     <= 1'b0;
      rdata   <= `VPS_BUS_ZERO;
      run     <= `VPS_CTRL_RUN_RST;
      prst_req <= 1'b0;
      ovr     <= 1'b0;
    end else begin
      ack     <= next_ack;
      rdata   <= next_rdata;
      run     <= next_run;
      prst_req <= next_prst_req;
      ovr     <= next_ovr;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  load_xfer_a: assert property (ld |=> shreg == $past(held))
    else $error("load did not copy held word");
  freeze_hold_a: assert property (
    pix_rise && s2.ctl.freeze |=> $stable(shreg) && $stable(ser_out_o))
    else $error("shifter moved while frozen");
  force_lvl_a: assert property (
    shift_ev && s2.ctl.force_out |=>
      ser_out_o == $past(s2.ctl.force_level) &&
      mid_tap_output_o == $past(s2.ctl.force_level))
    else $error("forced level not shown");
  shift_step_a: assert property (
    shift_ev && !ld && !s2.ctl.force_out |=>
      ser_out_o == $past(shreg[1]) &&
      shreg[W-2:0] == $past(shreg[W-1:1]))
    else $error("shift step wrong");
  mid_tap_a: assert property (
    shift_ev && !ld && !s2.ctl.force_out |=>
      mid_tap_output_o == $past(shreg[`VPS_MID_BIT+1]))
    else $error("mid tap wrong");
  load_ignore_a: assert property (
    !s2.ctl.load_en |=> !pend)
    else $error("load accepted while disabled");
  ptr_reset_a: assert property (
    m1_fall && s2.load |=> cnt == 3'd0 && wptr == 2'd0 && rptr == 2'd0)
    else $error("pointer reset missed");
  stage_cap_a: assert property (cnt <= `VPS_STAGE_DEPTH)
    else $error("stage overfilled");
  fifo_pop_a: assert property (
    fifo_ld && !fifo_wr && !prst |=> cnt == $past(cnt) - 3'd1)
    else $error("stage count not reduced by load");
  mode_dec_a: assert property (
    s2.ctl.mode_sel_bit0 |-> mode == VPS_MODE_LATCH)
    else $error("latch mode not chosen");
  bus_ack_a: assert property (
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");

  load_seen_c:  cover property (ld ##[1:40] (shift_ev && !ld));
  stage_full_c: cover property (cnt == `VPS_STAGE_DEPTH);
  force_c:      cover property (shift_ev && s2.ctl.force_out);
  ptr_reset_c:  cover property (m1_fall && s2.load);

endmodule // vps_video_shifter

/* testbench/vps_partner.sv */
// Purpose: Word writer and load/pixel timing source for the shifter
// Assumes: Driven from the bench clock; pins change right after an edge
// Notes:   A released data bus shows the inverse of the last word
`timescale 1ns/1ns
module vps_partner (
  // Clock
  input  wire logic   clk_i,
  // Writer and timing pins
  output logic        wr_strobe_o,
  output logic [15:0] wr_data_o,
  output logic        load_o,
  output logic        pix_o
);
  initial begin
    wr_strobe_o = 1'b0;
    wr_data_o   = 16'h0000;
    load_o      = 1'b0;
    pix_o       = 1'b0;
  end

  // Ten clocks a word keeps the writer well inside its rate
  // At most four unloaded words, except when the bench fills the buffer
  task automatic write_word(input logic [15:0] d);
    @(posedge clk_i);
    wr_data_o <= d;
    repeat (3) @(posedge clk_i);
    wr_strobe_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    wr_strobe_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    wr_data_o <= ~d;
  endtask

  // Word left on the bus with the strobe low, for latch mode
  task automatic present_word(input logic [15:0] d);
    @(posedge clk_i);
    wr_data_o <= d;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic load_pulse();
    @(posedge clk_i);
    load_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    load_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // Level change on the load pin, for the pointer reset pulse
  task automatic load_level(input logic v);
    @(posedge clk_i);
    load_o <= v;
    repeat (4) @(posedge clk_i);
  endtask

  // Nine clocks a period, far below the pixel rate ceiling
  task automatic pix_pulse();
    @(posedge clk_i);
    pix_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    pix_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // vps_partner

/* testbench/test_vps_video_shifter.sv */
// Purpose: Self-checking bench for the video shifter
// Assumes: Partner model drives writer, load and pixel pins
// Notes:   Pixel periods are slow so every pin event is synchronised
`timescale 1ns/1ns
module test_vps_video_shifter;
  import vps_pkg::*;
  logic        clk_i   = 1'b0;
  logic        srst_i  = 1'b1;
  logic [3:0]  addr    = 4'h0;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  be      = 4'hF;
  logic [31:0] rdata;
  logic [31:0] q;
  logic        waitreq;
  logic        wr_stb;
  logic [15:0] wr_data;
  logic        load_stb;
  logic        pix;
  logic        wr_ready;
  logic        ser_out;
  logic        mid_tap;
  vps_ctl_t    ctl     = '0;
  logic        ser_in  = 1'b0;
  int          n_fail  = 0;
  int          n_tests = 0;

  always #20 clk_i = ~clk_i;

  vps_partner partner (.clk_i(clk_i), .wr_strobe_o(wr_stb),
    .wr_data_o(wr_data), .load_o(load_stb), .pix_o(pix));

  vps_video_shifter DUT (.clk_i(clk_i), .srst_i(srst_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .wr_strobe_i(wr_stb), .wr_data_i(wr_data), .wr_ready_o(wr_ready),
    .ctl_i(ctl), .load_strobe_i(load_stb), .pix_clk_i(pix),
    .ser_in_i(ser_in), .ser_out_o(ser_out), .mid_tap_output_o(mid_tap));

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Request held until an edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    rd    <= ~w;
    wr    <= w;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0) begin
      n_fail++;
      test_done();
    end
  endtask

  task automatic set_ctl(input logic [5:0] c);
    @(posedge clk_i);
    ctl <= vps_ctl_t'(c);
    repeat (4) @(posedge clk_i);
  endtask

  task automatic shift_chk(input logic [15:0] w, input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      partner.pix_pulse();
      chk("ser_out", ser_out, w[i]);
      if (i < 8)
        chk("mid_tap", mid_tap, w[i+8]);
    end
  endtask

  function automatic logic [15:0] wk(input int k);
    return 16'(k * 257) ^ 16'h5A3C;
  endfunction

  task automatic t_regs();
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl", q, 32'h0000_0001);
    // Lane 0 disabled: the run bit must not clear
    @(posedge clk_i);
    be <= 4'h0;
    bus(1'b1, 4'h0, 32'h0);
    be <= 4'hF;
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl_be", q, 32'h0000_0001);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", q, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_flop();
    set_ctl(6'h01);
    bus(1'b0, 4'h4, 32'h0);
    chk("mode", q[5:4], 32'h1);
    partner.write_word(16'hA5C3);
    partner.write_word(16'h3C96);
    partner.load_pulse();
    shift_chk(16'h3C96, 0, 15);
    $display("test flop done");
  endtask

  task automatic t_latch();
    logic [5:0] codes [2] = '{6'h11, 6'h31};
    for (int m = 0; m < 2; m++) begin
      set_ctl(codes[m]);
      bus(1'b0, 4'h4, 32'h0);
      chk("mode", q[5:4], 32'h0);
      partner.present_word(16'h9E61 ^ 16'(m));
      partner.load_pulse();
      shift_chk(16'h9E61 ^ 16'(m), 0, 15);
    end
    $display("test latch done");
  endtask

  task automatic t_freeze();
    set_ctl(6'h01);
    partner.write_word(16'hB2D4);
    partner.load_pulse();
    shift_chk(16'hB2D4, 0, 2);
    set_ctl(6'h09);
    repeat (3) partner.pix_pulse();
    chk("ser_out", ser_out, 32'(16'hB2D4 >> 2) & 32'h1);
    chk("mid_tap", mid_tap, 32'(16'hB2D4 >> 10) & 32'h1);
    bus(1'b0, 4'h8, 32'h0);
    chk("shift", q, 32'h0000_2CB5);
    set_ctl(6'h01);
    shift_chk(16'hB2D4, 3, 15);
    $display("test freeze done");
  endtask

  // Forced bits differ from the word, so a missing force shows
  task automatic t_force();
    partner.write_word(16'h0C0C);
    set_ctl(6'h07);
    partner.load_pulse();
    for (int i = 0; i < 4; i++) begin
      if (i == 2)
        set_ctl(6'h05);
      partner.pix_pulse();
      chk("ser_out", ser_out, (i < 2) ? 32'h1 : 32'h0);
      chk("mid_tap", mid_tap, (i < 2) ? 32'h1 : 32'h0);
    end
    set_ctl(6'h01);
    shift_chk(16'h0C0C, 4, 15);
    $display("test force done");
  endtask

  task automatic t_loaden();
    ser_in <= 1'b1;
    repeat (16) partner.pix_pulse();
    chk("ser_in", ser_out, 32'h1);
    ser_in <= 1'b0;
    repeat (16) partner.pix_pulse();
    set_ctl(6'h00);
    partner.write_word(16'hFFFF);
    partner.load_pulse();
    repeat (3) begin
      partner.pix_pulse();
      chk("ser_out", ser_out, 32'h0);
      chk("mid_tap", mid_tap, 32'h0);
    end
    set_ctl(6'h01);
    partner.load_pulse();
    shift_chk(16'hFFFF, 0, 0);
    $display("test load enable done");
  endtask

  // Stage takes four words, then the buffer fills and refuses
  task automatic t_fifo();
    set_ctl(6'h21);
    bus(1'b1, 4'h0, 32'h0000_0003);
    bus(1'b0, 4'h4, 32'h0);
    chk("mode", q[5:4], 32'h2);
    chk("count", q[2:0], 32'h0);
    for (int k = 0; k < 36; k++)
      partner.write_word(wk(k));
    chk("wr_ready", wr_ready, 32'h0);
    bus(1'b0, 4'h4, 32'h0);
    chk("count", q[2:0], 32'h4);
    chk("level", q[13:8], 32'd32);
    partner.write_word(16'hDEAD);
    bus(1'b0, 4'h4, 32'h0);
    chk("overrun", q[3], 32'h1);
    for (int k = 0; k < 36; k++) begin
      partner.load_pulse();
      partner.pix_pulse();
      chk("ser_out", ser_out, 32'(wk(k) & 16'h0001));
      chk("mid_tap", mid_tap, 32'(wk(k) >> 8) & 32'h1);
    end
    chk("wr_ready", wr_ready, 32'h1);
    partner.write_word(wk(1));
    partner.write_word(wk(2));
    bus(1'b0, 4'h4, 32'h0);
    chk("count", q[2:0], 32'h2);
    // Mode bit 1 pulsed low while the load pin is high
    partner.load_level(1'b1);
    set_ctl(6'h01);
    set_ctl(6'h21);
    partner.load_level(1'b0);
    bus(1'b0, 4'h4, 32'h0);
    chk("count", q[2:0], 32'h0);
    bus(1'b1, 4'h4, 32'h0000_0008);
    bus(1'b0, 4'h4, 32'h0);
    chk("status", q & 32'h0000_3F0F, 32'h0);
    $display("test fifo done");
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_flop();
    t_latch();
    t_freeze();
    t_force();
    t_loaden();
    t_fifo();
    test_done();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    test_done();
  end
endmodule // test_vps_video_shifter
